//--- include/async_bus_pkg.sv
package async_bus_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int SEP_ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int MUX_LINES_W = 22;
  localparam int IO_DECODE_W = 13;
  localparam int MEM_WORDS_DEF = 256;
  localparam int FIFO_DEPTH_DEF = 16;

  // ----------------------------------------------------------------
  // transfer codes on the separate-line bus (active-high view)
  // ----------------------------------------------------------------
  localparam logic [1:0] CODE_WORD_READ = 2'h0;
  localparam logic [1:0] CODE_READ_NO_RESTORE = 2'h1;
  localparam logic [1:0] CODE_WORD_WRITE = 2'h2;
  localparam logic [1:0] CODE_BYTE_WRITE = 2'h3;

  // ----------------------------------------------------------------
  // address windows and byte lanes
  // ----------------------------------------------------------------
  localparam logic [MUX_LINES_W-1:0] MEM_BASE_DEF = 22'h000000;
  localparam logic [IO_DECODE_W-1:0] IO_BASE_DEF = 13'h1000;
  localparam logic [DATA_W-1:0] MASK_WORD = 16'hFFFF;
  localparam logic [DATA_W-1:0] MASK_HIGH = 16'hFF00;
  localparam logic [DATA_W-1:0] MASK_LOW = 16'h00FF;
  localparam logic [MUX_LINES_W-1:0] WORD_STEP = 22'h000002;

  // ----------------------------------------------------------------
  // trap and restart vectors (octal 4, 114, 24)
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] VEC_TIMEOUT = 16'h0004;
  localparam logic [DATA_W-1:0] VEC_PARITY = 16'h004C;
  localparam logic [DATA_W-1:0] VEC_RESTART = 16'h0014;

  // ----------------------------------------------------------------
  // pin groups; *_n fields are raw low-active line levels
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SEP_ADDR_W-1:0] addr_n;
    logic [1:0] code_n;
    logic [DATA_W-1:0] data_n;
    logic pa_n;
    logic pb_n;
    logic msync_n;
    logic intr_n;
    logic bbsy_n;
  } sep_pins_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic pa;
    logic pb;
    logic ssyn;
  } sep_drive_type;

  typedef struct packed {
    logic [MUX_LINES_W-1:0] dal_n;
    logic sync_n;
    logic din_n;
    logic dout_n;
    logic wtbt_n;
    logic bs7_n;
    logic refresh_n;
  } mux_pins_type;

  typedef struct packed {
    logic [MUX_LINES_W-1:0] dal;
    logic rply;
    logic refresh;
  } mux_drive_type;

  typedef struct packed {
    logic [MUX_LINES_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic byte_write;
    logic from_mux;
  } wr_word_type;

endpackage : async_bus_pkg

//--- rtl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync
  import async_bus_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // level in, level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // meta_reg feeds only q
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : pin_sync

//--- rtl/word_fifo.sv
`timescale 1ns/1ns
module word_fifo
  import async_bus_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [PW:0] wr_ptr_reg;
  logic [PW:0] rd_ptr_reg;

  wire ptr_low_eq = wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0];
  wire full = ptr_low_eq && (wr_ptr_reg[PW] != rd_ptr_reg[PW]);
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = !full;
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = store_reg[rd_ptr_reg[PW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      store_reg[wr_ptr_reg[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (PW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (PW+1)'(pop);
    end
  end

endmodule : word_fifo

//--- rtl/async_bus_slave.sv
`timescale 1ns/1ns
// Functional notes
// - separate lines: 18-bit address, two-bit transfer code
// - separate lines: 16 data bits, two parity lines
// - matched slave answers sync after data ready/stored
// - interrupt strobe with vector answered by slave sync
// - data lines used only while bus busy held
// - 22 shared lines carry address, then data words
// - multiplexed transfer type set by strobes and controls
// - write/byte line: write cycle, then byte write
// - io page select: decode address bits 12..0
// - block read continues on select plus refresh line
// - refresh line: master refresh, slave block continue
// - reply: data coming, or write data taken
// - halt stops after current instruction completes
// - line clock gives one tick per mains cycle
// - power return: restart via 24 or reboot
// - cycle ends on slave answer, or when the master gives up after a bounded wait
// - slave reports read parity error on parity lines
// - bus lines open drain, asserted low
module async_bus_slave
  import async_bus_pkg::*;
#(
  parameter int MEM_WORDS = MEM_WORDS_DEF,
  parameter logic [MUX_LINES_W-1:0] MEM_BASE = MEM_BASE_DEF,
  parameter logic [IO_DECODE_W-1:0] IO_BASE = IO_BASE_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // separate-line bus
  input wire sep_pins_type SEP_IN,
  output sep_drive_type SEP_OUT,
  output sep_drive_type SEP_OE,
  // multiplexed bus
  input wire mux_pins_type MUX_IN,
  output mux_drive_type MUX_OUT,
  output mux_drive_type MUX_OE,
  // miscellaneous lines
  input wire logic HALT_N,
  input wire logic LINE_TIME_CLOCK,
  input wire logic BOOT_ENABLE_N,
  // processor core side
  input wire logic INSTR_DONE,
  input wire logic POWER_RESTORED,
  input wire logic FORCE_PARITY_ERR,
  output logic CORE_HALTED,
  output logic LINE_TIME_EVENT,
  output logic RESTART_VALID,
  output logic [DATA_W-1:0] RESTART_VECTOR,
  output logic REBOOT,
  output logic VECTOR_VALID,
  output logic [DATA_W-1:0] VECTOR_ADDR,
  // write stream out
  output logic WR_VALID,
  input wire logic WR_READY,
  output wr_word_type WR_DATA
);

  localparam int AW = $clog2(MEM_WORDS);

  typedef enum {U_IDLE, U_ANS, U_SKIP} u_state_type;
  typedef enum {M_IDLE, M_ACTIVE, M_READ, M_WRITE, M_SKIP} m_state_type;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sep_pins_type sep_s;
  mux_pins_type mux_s;
  logic halt_s_n;
  logic ltc_s;
  logic boot_s_n;

  pin_sync #(.W($bits(sep_pins_type)), .INIT('1)) u_sep_sync (
    .clk(REF_CLK),
    .srst(SRST),
    .d(SEP_IN),
    .q(sep_s)
  );
  pin_sync #(.W($bits(mux_pins_type)), .INIT('1)) u_mux_sync (
    .clk(REF_CLK),
    .srst(SRST),
    .d(MUX_IN),
    .q(mux_s)
  );
  pin_sync #(.W(3), .INIT(3'h5)) u_misc_sync (
    .clk(REF_CLK),
    .srst(SRST),
    .d({HALT_N, LINE_TIME_CLOCK, BOOT_ENABLE_N}),
    .q({halt_s_n, ltc_s, boot_s_n})
  );

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  u_state_type u_state_reg, u_state_next;
  m_state_type m_state_reg, m_state_next;
  sep_drive_type sep_drive_reg, sep_drive_next;
  mux_drive_type mux_drive_reg, mux_drive_next;
  logic [MUX_LINES_W-1:0] m_addr_reg, m_addr_next;
  logic m_wtbt_reg, m_wtbt_next;
  logic vec_valid_next;
  logic [DATA_W-1:0] mem_reg [MEM_WORDS];
  logic par_reg [MEM_WORDS];
  logic fifo_ready;
  logic ltc_prev_reg;
  wr_word_type fifo_in;

  // ----------------------------------------------------------------
  // separate-line decode
  // ----------------------------------------------------------------
  wire msync_a = !sep_s.msync_n;
  wire intr_a = !sep_s.intr_n;
  wire bbsy_a = !sep_s.bbsy_n;
  wire [SEP_ADDR_W-1:0] sep_addr = ~sep_s.addr_n;
  wire [1:0] sep_code = ~sep_s.code_n;
  wire [DATA_W-1:0] sep_wdata = ~sep_s.data_n;
  wire sep_is_byte = sep_code == CODE_BYTE_WRITE;
  wire sep_is_wr = sep_is_byte || (sep_code == CODE_WORD_WRITE);
  wire sep_hit = sep_addr[SEP_ADDR_W-1:AW+1] == MEM_BASE[SEP_ADDR_W-1:AW+1];
  wire sep_go = msync_a && bbsy_a && sep_hit;
  wire [DATA_W-1:0] sep_word = mem_reg[sep_addr[AW:1]];
  wire sep_perr = (^sep_word) ^ par_reg[sep_addr[AW:1]];

  // ----------------------------------------------------------------
  // multiplexed decode
  // ----------------------------------------------------------------
  wire [MUX_LINES_W-1:0] dal_in = ~mux_s.dal_n;
  wire sync_a = !mux_s.sync_n;
  wire din_a = !mux_s.din_n;
  wire dout_a = !mux_s.dout_n;
  wire wtbt_a = !mux_s.wtbt_n;
  wire bs7_a = !mux_s.bs7_n;
  wire refresh_a = !mux_s.refresh_n;
  wire io_hit = dal_in[IO_DECODE_W-1:AW+1] == IO_BASE[IO_DECODE_W-1:AW+1];
  wire mem_hit = dal_in[MUX_LINES_W-1:AW+1] == MEM_BASE[MUX_LINES_W-1:AW+1];
  wire mux_hit = (bs7_a ? io_hit : mem_hit) && !refresh_a;
  wire m_last = &m_addr_reg[AW:1];
  wire [DATA_W-1:0] m_word = mem_reg[m_addr_reg[AW:1]];
  wire m_perr = (^m_word) ^ par_reg[m_addr_reg[AW:1]];
  wire m_wr = (m_state_reg == M_ACTIVE) && sync_a && !din_a && dout_a && fifo_ready;
  wire m_more = din_a ? bs7_a : m_wtbt_reg;
  // parity enable above the error bit, data below
  wire [MUX_LINES_W-1:0] m_read_dal = {4'h0, 1'b1, m_perr, m_word};

  // separate-line writes yield to the multiplexed side for one cycle
  wire u_rd = (u_state_reg == U_IDLE) && sep_go && !sep_is_wr;
  wire u_wr = (u_state_reg == U_IDLE) && sep_go && sep_is_wr && fifo_ready && !m_wr;

  // ----------------------------------------------------------------
  // shared write port
  // ----------------------------------------------------------------
  wire mem_we = m_wr || u_wr;
  wire [AW-1:0] wr_idx = m_wr ? m_addr_reg[AW:1] : sep_addr[AW:1];
  wire [DATA_W-1:0] wr_data = m_wr ? dal_in[DATA_W-1:0] : sep_wdata;
  wire wr_byte = m_wr ? wtbt_a : sep_is_byte;
  wire wr_hi = m_wr ? m_addr_reg[0] : sep_addr[0];
  wire [DATA_W-1:0] wr_mask = !wr_byte ? MASK_WORD : (wr_hi ? MASK_HIGH : MASK_LOW);
  wire [DATA_W-1:0] wr_word = (mem_reg[wr_idx] & ~wr_mask) | (wr_data & wr_mask);

  assign fifo_in = '{addr: m_wr ? m_addr_reg : MUX_LINES_W'(sep_addr),
                     data: wr_data, byte_write: wr_byte, from_mux: m_wr};

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem_reg[i] <= '0;
        par_reg[i] <= 1'b0;
      end
    end else if (mem_we) begin
      mem_reg[wr_idx] <= wr_word;
      par_reg[wr_idx] <= (^wr_word) ^ FORCE_PARITY_ERR;
    end
  end

  // a full FIFO holds the slave answer back, stalling the master
  word_fifo #(.WIDTH($bits(wr_word_type)), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clk(REF_CLK),
    .srst(SRST),
    .in_valid(mem_we),
    .in_ready(fifo_ready),
    .in_data(fifo_in),
    .out_valid(WR_VALID),
    .out_ready(WR_READY),
    .out_data(WR_DATA)
  );

  // ----------------------------------------------------------------
  // separate-line slave
  // ----------------------------------------------------------------
  always_comb begin
    u_state_next = u_state_reg;
    sep_drive_next = sep_drive_reg;
    vec_valid_next = 1'b0;
    case (u_state_reg)
      U_IDLE: begin
        if (u_rd) begin
          sep_drive_next = '{data: sep_word, pa: 1'b0, pb: sep_perr, ssyn: 1'b1};
          u_state_next = U_ANS;
        end else if (u_wr) begin
          sep_drive_next.ssyn = 1'b1;
          u_state_next = U_ANS;
        end else if (msync_a && bbsy_a && !sep_hit) begin
          u_state_next = U_SKIP;
        end else if (intr_a && !msync_a && bbsy_a) begin
          vec_valid_next = 1'b1;
          sep_drive_next.ssyn = 1'b1;
          u_state_next = U_ANS;
        end
      end
      U_ANS: begin
        if (!msync_a && !intr_a) begin
          sep_drive_next = '0;
          u_state_next = U_IDLE;
        end
      end
      U_SKIP: begin
        if (!msync_a) begin
          u_state_next = U_IDLE;
        end
      end
      default: begin
        sep_drive_next = '0;
        u_state_next = U_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // multiplexed slave
  // ----------------------------------------------------------------
  always_comb begin
    m_state_next = m_state_reg;
    mux_drive_next = mux_drive_reg;
    m_addr_next = m_addr_reg;
    m_wtbt_next = m_wtbt_reg;
    case (m_state_reg)
      M_IDLE: begin
        if (sync_a) begin
          m_addr_next = dal_in;
          m_wtbt_next = wtbt_a;
          m_state_next = mux_hit ? M_ACTIVE : M_SKIP;
        end
      end
      M_ACTIVE: begin
        if (!sync_a) begin
          m_state_next = M_IDLE;
        end else if (din_a) begin
          mux_drive_next = '{dal: m_read_dal, rply: 1'b1, refresh: m_more && !m_last};
          m_state_next = M_READ;
        end else if (m_wr) begin
          mux_drive_next = '{dal: '0, rply: 1'b1, refresh: m_more && !m_last};
          m_state_next = M_WRITE;
        end
      end
      M_READ: begin
        if (!din_a) begin
          mux_drive_next = '0;
          if (bs7_a && !m_last) begin
            m_addr_next = m_addr_reg + WORD_STEP;
          end
          m_state_next = M_ACTIVE;
        end
      end
      M_WRITE: begin
        if (!dout_a) begin
          mux_drive_next = '0;
          if (m_wtbt_reg && !m_last) begin
            m_addr_next = m_addr_reg + WORD_STEP;
          end
          m_state_next = M_ACTIVE;
        end
      end
      M_SKIP: begin
        if (!sync_a) begin
          m_state_next = M_IDLE;
        end
      end
      default: begin
        mux_drive_next = '0;
        m_state_next = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      u_state_reg <= U_IDLE;
      m_state_reg <= M_IDLE;
      sep_drive_reg <= '0;
      mux_drive_reg <= '0;
      m_addr_reg <= '0;
      m_wtbt_reg <= 1'b0;
    end else begin
      u_state_reg <= u_state_next;
      m_state_reg <= m_state_next;
      sep_drive_reg <= sep_drive_next;
      mux_drive_reg <= mux_drive_next;
      m_addr_reg <= m_addr_next;
      m_wtbt_reg <= m_wtbt_next;
    end
  end

  // open drain: the level is always low, the enable asserts the line
  assign SEP_OUT = '0;
  assign MUX_OUT = '0;
  assign SEP_OE = sep_drive_reg;
  assign MUX_OE = mux_drive_reg;
  assign RESTART_VECTOR = VEC_RESTART;

  // ----------------------------------------------------------------
  // vector capture, halt, line clock, power return
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      VECTOR_VALID <= 1'b0;
      VECTOR_ADDR <= '0;
      CORE_HALTED <= 1'b0;
      ltc_prev_reg <= 1'b0;
      LINE_TIME_EVENT <= 1'b0;
      RESTART_VALID <= 1'b0;
      REBOOT <= 1'b0;
    end else begin
      VECTOR_VALID <= vec_valid_next;
      if (vec_valid_next) begin
        VECTOR_ADDR <= sep_wdata;
      end
      if (!halt_s_n && INSTR_DONE) begin
        CORE_HALTED <= 1'b1;
      end else if (halt_s_n) begin
        CORE_HALTED <= 1'b0;
      end
      ltc_prev_reg <= ltc_s;
      LINE_TIME_EVENT <= ltc_s && !ltc_prev_reg;
      RESTART_VALID <= POWER_RESTORED && boot_s_n;
      REBOOT <= POWER_RESTORED && !boot_s_n;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  a_sep_read_data: assert property (u_rd |=> SEP_OE.ssyn && SEP_OE.data == $past(sep_word))
    else $error("read answer without the addressed word");
  a_sep_write_ans: assert property (u_wr |=> SEP_OE.ssyn ##1 (SEP_OE.ssyn || !msync_a))
    else $error("write answer missing or dropped early");
  a_sep_no_stray: assert property (u_state_reg == U_SKIP |-> !SEP_OE.ssyn)
    else $error("unaddressed slave drove sync");
  a_vector_take: assert property (vec_valid_next |=> VECTOR_VALID && SEP_OE.ssyn ##1 !VECTOR_VALID)
    else $error("vector not taken as one pulse with answer");
  a_mux_reply_hold: assert property (MUX_OE.rply && (din_a || dout_a) |=> MUX_OE.rply)
    else $error("reply removed while master strobe held");
  a_mux_read_reply: assert property (m_state_reg == M_ACTIVE && sync_a && din_a
      |=> MUX_OE.rply && MUX_OE.dal[DATA_W-1:0] == $past(m_word))
    else $error("data-in not answered with data");
  a_refresh_block: assert property (MUX_OE.refresh |-> MUX_OE.rply)
    else $error("continue line driven outside a reply");
  a_cycle_end: assert property (m_state_reg != M_IDLE && !sync_a && !MUX_OE.rply
      |=> m_state_reg == M_IDLE)
    else $error("slave did not leave the ended cycle");
  // the halt may only be let go one cycle after the synced line negates
  a_halt_stop: assert property (!halt_s_n && INSTR_DONE |=> CORE_HALTED ##1
      (CORE_HALTED || $past(halt_s_n)))
    else $error("halt not taken at instruction end");
  a_line_tick: assert property (LINE_TIME_EVENT |=> !LINE_TIME_EVENT)
    else $error("line tick longer than one cycle");
  a_boot_choice: assert property (POWER_RESTORED |=> (RESTART_VALID ^ REBOOT)
      && (REBOOT == !$past(boot_s_n)))
    else $error("wrong power-return action");

  c_block_read: cover property (MUX_OE.refresh && din_a ##[1:20] m_state_reg == M_READ);
  c_sep_write: cover property (u_wr ##[1:20] u_state_reg == U_IDLE);
  c_vector: cover property (VECTOR_VALID);
  c_fifo_full: cover property (!fifo_ready && sync_a && dout_a);

endmodule : async_bus_slave

//--- verification/bus_master_model.sv
`timescale 1ns/1ns
module bus_master_model
  import async_bus_pkg::*;
(
  // clock
  input wire logic clk,
  // slave pulls
  input wire sep_drive_type sep_oe,
  input wire mux_drive_type mux_oe,
  // line levels
  output sep_pins_type sep_in,
  output mux_pins_type mux_in
);
  // master pulls, 1 = low; a released line rises on its pull-up
  sep_pins_type ms = '0;
  mux_pins_type mm = '0;
  // set by the bench to run a cycle without owning the data section
  logic no_busy = 1'b0;
  always_comb begin
    sep_in = ~ms;
    sep_in.data_n = ~(ms.data_n | sep_oe.data);
    sep_in.pb_n = ~(ms.pb_n | sep_oe.pb);
    mux_in = ~mm;
    mux_in.dal_n = ~(mm.dal_n | mux_oe.dal);
    mux_in.refresh_n = ~(mm.refresh_n | mux_oe.refresh);
  end
  // gives up after a bounded wait, as a master abandons a dead cycle
  task automatic await(input bit mx, input logic lvl, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 24 && !ok; n++) begin
      @(negedge clk);
      ok = ((mx ? mux_oe.rply : sep_oe.ssyn) === lvl);
    end
  endtask : await
  task automatic sep_op(input logic [1:0] code, input logic [SEP_ADDR_W-1:0] adr,
      input logic [DATA_W-1:0] wd, input logic vec, output logic [DATA_W:0] rd,
      output logic ok);
    logic gone;
    @(negedge clk);
    ms.addr_n = adr;
    ms.code_n = code;
    ms.data_n = (code[1] || vec) ? wd : '0;
    ms.bbsy_n = !no_busy;
    @(negedge clk);
    ms.intr_n = vec;
    ms.msync_n = !vec;
    await(1'b0, 1'b1, ok);
    rd = {~sep_in.pb_n, ~sep_in.data_n};
    ms.msync_n = 1'b0;
    ms.intr_n = 1'b0;
    await(1'b0, 1'b0, gone);
    ms = '0;
  endtask : sep_op
  task automatic mux_op(input logic [MUX_LINES_W-1:0] adr, input logic io, wr, bw,
      input logic [DATA_W-1:0] wd, input int nw, output logic [1:0][DATA_W:0] rd,
      output logic ok);
    logic got, gone, more;
    @(negedge clk);
    mm.dal_n = adr;
    mm.bs7_n = io;
    mm.wtbt_n = wr;
    @(negedge clk);
    mm.sync_n = 1'b1;
    @(negedge clk);
    mm.dal_n = wr ? 22'(wd) : '0;
    mm.wtbt_n = bw;
    ok = 1'b1;
    for (int i = 0; i < nw && ok; i++) begin
      mm.bs7_n = !wr && i < nw - 1;
      @(negedge clk);
      mm.din_n = !wr;
      mm.dout_n = wr;
      await(1'b1, 1'b1, got);
      rd[i] = ~mux_in.dal_n[DATA_W:0];
      more = mux_oe.refresh;
      mm.din_n = 1'b0;
      mm.dout_n = 1'b0;
      await(1'b1, 1'b0, gone);
      ok = got && gone && (more || i == nw - 1);
    end
    mm = '0;
  endtask : mux_op
endmodule : bus_master_model

//--- verification/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import async_bus_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, halt_n = 1'b1, line_time_clock = 1'b0, boot_n = 1'b1;
  logic done = 1'b0, pwr = 1'b0, perr = 1'b0, wr_ready = 1'b0, ok, pm [MEM_WORDS_DEF];
  logic halted, lte, rst_v, reboot, vec_v, wr_valid;
  logic [DATA_W-1:0] rst_vec, vec_addr, w, mem [MEM_WORDS_DEF];
  logic [DATA_W:0] rd;
  logic [1:0][DATA_W:0] rb;
  logic [SEP_ADDR_W-1:0] a;
  logic [1:0] c;
  logic [31:0] seed = 32'h7055;
  sep_pins_type sep_in;
  sep_drive_type sep_oe, sep_lvl;
  mux_pins_type mux_in;
  mux_drive_type mux_oe, mux_lvl;
  wr_word_type wr_data, fq [$];
  int mismatches = 0, total_checks = 0, n_lte = 0, n_rst = 0, n_boot = 0, n_vec = 0;

  always #5 clk = ~clk;

  async_bus_slave uut (
    .REF_CLK(clk), .SRST(srst), .SEP_IN(sep_in), .SEP_OUT(sep_lvl), .SEP_OE(sep_oe),
    .MUX_IN(mux_in), .MUX_OUT(mux_lvl), .MUX_OE(mux_oe), .HALT_N(halt_n),
    .LINE_TIME_CLOCK(line_time_clock), .BOOT_ENABLE_N(boot_n), .INSTR_DONE(done),
    .POWER_RESTORED(pwr), .FORCE_PARITY_ERR(perr), .CORE_HALTED(halted),
    .LINE_TIME_EVENT(lte), .RESTART_VALID(rst_v), .RESTART_VECTOR(rst_vec),
    .REBOOT(reboot), .VECTOR_VALID(vec_v), .VECTOR_ADDR(vec_addr),
    .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data)
  );
  bus_master_model mdl (
    .clk(clk), .sep_oe(sep_oe), .mux_oe(mux_oe), .sep_in(sep_in), .mux_in(mux_in)
  );

  always @(posedge clk) begin
    if (lte === 1'b1) n_lte++;
    if (rst_v === 1'b1) n_rst++;
    if (reboot === 1'b1) n_boot++;
    if (vec_v === 1'b1) n_vec++;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, wd, logic bw, hi);
    return !bw ? wd : hi ? {wd[15:8], o[7:0]} : {o[15:8], wd[7:0]};
  endfunction : merge
  task automatic check(input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic wr_do(input bit mx, input logic [1:0] cd, input logic [MUX_LINES_W-1:0] adr);
    if (mx) mdl.mux_op(adr, 1'b0, 1'b1, cd[0], w, 1, rb, ok);
    else mdl.sep_op(cd, 18'(adr), w, 1'b0, rd, ok);
    check(ok, 1'b1);
    mem[adr[8:1]] = merge(mem[adr[8:1]], w, cd[0], adr[0]);
    pm[adr[8:1]] = perr;
  endtask : wr_do
  task automatic rd_chk(input bit mx, input logic [1:0] cd,
      input logic [MUX_LINES_W-1:0] adr, input logic io);
    if (mx) mdl.mux_op(adr, io, 1'b0, 1'b0, '0, 1, rb, ok);
    else mdl.sep_op(cd, 18'(adr), '0, 1'b0, rb[0], ok);
    check(ok, 1'b1);
    check(rb[0], {pm[adr[8:1]], mem[adr[8:1]]});
  endtask : rd_chk

  initial begin
    foreach (mem[i]) begin
      mem[i] = '0;
      pm[i] = 1'b0;
    end
    repeat (6) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    check({sep_oe, mux_oe, wr_valid}, '0);
    check({sep_lvl, mux_lvl}, '0);
    $display("reset test done");
    // drain stalled: sixteen writes fit, the next one gets no answer
    for (int i = 0; i <= FIFO_DEPTH_DEF; i++) begin
      a = 18'(rnd()) & 18'h001FE;
      w = 16'(rnd());
      // the write that finds the buffer full goes over the shared lines
      if (i == FIFO_DEPTH_DEF) mdl.mux_op(22'(a), 1'b0, 1'b1, 1'b0, w, 1, rb, ok);
      else mdl.sep_op(CODE_WORD_WRITE, a, w, 1'b0, rd, ok);
      check(ok, i < FIFO_DEPTH_DEF);
      if (ok) begin
        mem[a[8:1]] = w;
        fq.push_back({22'(a), w, 2'b00});
      end
    end
    for (int n = 0; n < 400 && fq.size() > 0; n++) begin
      @(negedge clk);
      wr_ready = 1'(rnd());
      if (wr_ready && wr_valid === 1'b1) check(wr_data, fq.pop_front());
    end
    @(negedge clk);
    check({fq.size(), wr_valid}, '0);
    wr_ready = 1'b1;
    $display("buffer test done");
    // every transfer code, writes read back over the other bus
    for (int i = 0; i < 16; i++) begin
      c = 2'(i);
      a = 18'(rnd()) & {17'h000FF, c[0]};
      w = 16'(rnd());
      if (c[1]) begin
        wr_do(i[2], c, 22'(a));
        rd_chk(!i[2], CODE_WORD_READ, 22'(a), 1'b0);
      end else
        rd_chk(i[2], c, 22'(a), 1'b0);
    end
    rd_chk(1'b1, 2'h0, {9'(rnd()), 4'h8, 9'(a)}, 1'b1);
    w = 16'(rnd());
    wr_do(1'b0, CODE_WORD_WRITE, 22'h20);
    w = ~w;
    wr_do(1'b1, CODE_WORD_WRITE, 22'h22);
    mdl.mux_op(22'h20, 1'b0, 1'b0, 1'b0, '0, 2, rb, ok);
    check({ok, rb}, {1'b1, 1'b0, w, 1'b0, ~w});
    mdl.sep_op(CODE_WORD_READ, 18'h3FF00, '0, 1'b0, rd, ok);
    check(ok, 1'b0);
    mdl.no_busy = 1'b1;
    mdl.sep_op(CODE_WORD_READ, 18'h20, '0, 1'b0, rd, ok);
    mdl.no_busy = 1'b0;
    check(ok, 1'b0);
    perr = 1'b1;
    wr_do(1'b0, CODE_WORD_WRITE, 22'h44);
    perr = 1'b0;
    rd_chk(1'b0, 2'h0, 22'h44, 1'b0);
    rd_chk(1'b1, 2'h0, 22'h44, 1'b0);
    mdl.sep_op(CODE_WORD_READ, '0, w, 1'b1, rd, ok);
    check({ok, vec_addr, n_vec[7:0]}, {1'b1, w, 8'd1});
    $display("bus test done");
    halt_n = 1'b0;
    repeat (4) @(negedge clk);
    check(halted, 1'b0);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    check(halted, 1'b1);
    halt_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      line_time_clock = i[0];
      repeat (4) @(negedge clk);
    end
    check({halted, n_lte[7:0]}, 9'd3);
    pwr = 1'b1;
    @(negedge clk);
    pwr = 1'b0;
    boot_n = 1'b0;
    repeat (4) @(negedge clk);
    pwr = 1'b1;
    @(negedge clk);
    pwr = 1'b0;
    repeat (3) @(negedge clk);
    check({n_rst[7:0], n_boot[7:0], rst_vec}, {8'd1, 8'd1, VEC_RESTART});
    $display("side line test done");
    end_of_test();
  end
endmodule : tb_top
